// ==== hw/idpw_top.sv ====
// Identify parameter words 55-85 with AHB-Lite register file
//
// Implementation choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/100ps
// How it works
// - Word 55 gives current heads, word 56 current sectors per track.
// - Words 57-58 give 32-bit current capacity from a variable register.
// - Word 59 bit 8 flags multiple setting valid, bits 7-0 hold count.
// - Words 60-61 give the fixed total addressable sector count.
// - Word 63 bits 10, 9, 8 flag multiword DMA mode 2, 1, 0 selected.
// - Word 63 bits 2-0 give fixed supported modes; reserved bits zero.
// - Word 64 bits 7-0 give advanced PIO modes; bits 15-8 zero.
// - Words 65 and 66 give minimum and recommended DMA cycle times.
// - Words 67 and 68 give PIO cycle times without and with flow control.
// - Words 69-74 and 76-79 read as reserved zero.
// - Word 75 bits 4-0 give queue depth; upper bits zero.
// - Word 80 is the major version bitmap; bit 4 claims this revision.
// - Word 81 carries the minor version code.
// - Word 82 is the supported command and feature bitmap.
// - Words 82 and 83 both zero or all ones mean no notification.
// - Word 83 reads bit 15 zero, bit 14 one, plus feature bits 4-0.
// - Word 84 reads bit 15 zero, bit 14 one, bits 13-0 zero.
// - Word 85 reflects enabled features and tracks device state.
// - Words 85-87 all zero or ones mean no enabled notification.
// - Every reserved bit and word returns zero.
// - 32-bit values go low word first, then high word.
// - Fixed words change only when removable media is changed.
module idpw_top #(
  parameter logic [2:0]  DMA_SUP   = 3'h7,
  parameter logic [7:0]  PIO_SUP   = 8'h03,
  parameter logic [15:0] DMA_MIN   = 16'h0078,
  parameter logic [15:0] DMA_REC   = 16'h0078,
  parameter logic [15:0] PIO_MIN   = 16'h0078,
  parameter logic [15:0] PIO_RDY   = 16'h0078,
  parameter logic [4:0]  QDEPTH    = 5'h00,
  parameter logic [15:0] MAJOR_VER = 16'h001E,
  parameter logic [15:0] MINOR_VER = 16'h0000,
  parameter logic [15:0] SUP82     = 16'h7E6B,
  parameter logic [4:0]  SUP83     = 5'h00,
  parameter bit          REMOVABLE = 1'b0
) (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        media_changed,
  input  wire logic        word_rd,
  input  wire logic [7:0]  word_idx,
  output logic [15:0]      word_data,
  output logic             word_valid,
  output logic             word_hit
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [31:0]         geom_r;
  logic [31:0]         cap_r;
  logic [31:0]         total_r;
  logic                multi_ok_r;
  logic [7:0]          multi_cnt_r;
  idpw_pkg::idpw_dma_t dma_sel_r;
  logic [15:0]         en_r;
  logic                total_lock_r;
  logic [7:0]          rd_cnt_r;
  logic [15:0]         cap_hi_r;
  logic                cap_pair_r;
  logic [15:0]         tot_hi_r;
  logic                tot_pair_r;
  logic                wr_pend_r;
  logic [7:0]          wr_addr_r;
  logic [31:0]         hrdata_r;
  logic                hready_r;
  logic                hresp_r;
  logic [15:0]         word_data_r;
  logic                word_valid_r;
  logic                word_hit_r;
  logic                addr_ok;
  logic                acc;
  logic                tot_wr_ok;
  logic [15:0]         word_nxt;

  idpw_cfg_if cfg ();

  // ----------------------------------------------------------------
  // Image lookup
  // ----------------------------------------------------------------
  assign cfg.heads     = geom_r[15:0];
  assign cfg.spt       = geom_r[31:16];
  assign cfg.cap       = cap_r;
  assign cfg.total     = total_r;
  assign cfg.multi_ok  = multi_ok_r;
  assign cfg.multi_cnt = multi_cnt_r;
  assign cfg.dma_sel   = dma_sel_r;
  assign cfg.en        = en_r;
  assign cfg.idx       = word_idx;

  idpw_word_mux #(
    .DMA_SUP   (DMA_SUP),
    .PIO_SUP   (PIO_SUP),
    .DMA_MIN   (DMA_MIN),
    .DMA_REC   (DMA_REC),
    .PIO_MIN   (PIO_MIN),
    .PIO_RDY   (PIO_RDY),
    .QDEPTH    (QDEPTH),
    .MAJOR_VER (MAJOR_VER),
    .MINOR_VER (MINOR_VER),
    .SUP82     (SUP82),
    .SUP83     (SUP83)
  ) u_mux (
    .c (cfg.img)
  );

  // High halves read right after their low half come from its snapshot
  always_comb begin
    word_nxt = cfg.word;
    if (word_idx == idpw_pkg::W_CAPHI && cap_pair_r) begin
      word_nxt = cap_hi_r;
    end else if (word_idx == idpw_pkg::W_TOTHI && tot_pair_r) begin
      word_nxt = tot_hi_r;
    end
  end

  // ----------------------------------------------------------------
  // Word read port
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      word_data_r  <= 16'h0000;
      word_valid_r <= 1'b0;
      word_hit_r   <= 1'b0;
      rd_cnt_r     <= 8'h00;
    end else begin
      word_valid_r <= word_rd;
      if (word_rd) begin
        word_data_r <= word_nxt;
        word_hit_r  <= cfg.hit;
        rd_cnt_r    <= rd_cnt_r + 8'h01;
      end
    end
  end

  // Low half read freezes the high half for the next transfer
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cap_hi_r   <= 16'h0000;
      cap_pair_r <= 1'b0;
      tot_hi_r   <= 16'h0000;
      tot_pair_r <= 1'b0;
    end else if (word_rd) begin
      cap_pair_r <= (word_idx == idpw_pkg::W_CAPLO);
      tot_pair_r <= (word_idx == idpw_pkg::W_TOTLO);
      if (word_idx == idpw_pkg::W_CAPLO) begin
        cap_hi_r <= cap_r[31:16];
      end
      if (word_idx == idpw_pkg::W_TOTLO) begin
        tot_hi_r <= total_r[31:16];
      end
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave, zero wait states, always OKAY
  // ----------------------------------------------------------------
  assign addr_ok = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0);
  assign acc     = hsel && hready && htrans[1];

  function automatic logic [31:0] reg_read(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      idpw_pkg::OFF_GEOM:   v = geom_r;
      idpw_pkg::OFF_CAP:    v = cap_r;
      idpw_pkg::OFF_MULTI:  v = {23'h000000, multi_ok_r, multi_cnt_r};
      idpw_pkg::OFF_DMASEL: v = {30'h00000000, dma_sel_r};
      idpw_pkg::OFF_ENABLE: v = {16'h0000, en_r};
      idpw_pkg::OFF_TOTAL:  v = total_r;
      idpw_pkg::OFF_STATUS: v = {21'h000000, tot_pair_r, cap_pair_r,
                                 total_lock_r, rd_cnt_r};
      default:              v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata_r  <= 32'h0000_0000;
      hready_r  <= 1'b1;
      hresp_r   <= 1'b0;
    end else begin
      hready_r  <= 1'b1;
      hresp_r   <= 1'b0;
      wr_pend_r <= acc && hwrite && addr_ok &&
                   (hsize == idpw_pkg::HSIZE_WORD);
      if (acc) begin
        wr_addr_r <= haddr[7:0];
      end
      if (acc && !hwrite) begin
        hrdata_r <= addr_ok ? reg_read(haddr[7:0]) : 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Variable parameter registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      geom_r      <= idpw_pkg::GEOM_RST;
      cap_r       <= idpw_pkg::CAP_RST;
      multi_ok_r  <= 1'b0;
      multi_cnt_r <= idpw_pkg::MULTI_RST;
      dma_sel_r   <= idpw_pkg::DMA_NONE;
      en_r        <= idpw_pkg::EN_RST;
    end else if (wr_pend_r) begin
      case (wr_addr_r)
        idpw_pkg::OFF_GEOM:   geom_r <= hwdata;
        idpw_pkg::OFF_CAP:    cap_r  <= hwdata;
        idpw_pkg::OFF_MULTI: begin
          multi_ok_r  <= hwdata[idpw_pkg::MULTI_OK_BIT];
          multi_cnt_r <= hwdata[7:0];
        end
        // Coded field keeps the selected mode single
        idpw_pkg::OFF_DMASEL:
          dma_sel_r <= idpw_pkg::idpw_dma_t'(hwdata[1:0]);
        idpw_pkg::OFF_ENABLE:
          en_r <= hwdata[15:0] & idpw_pkg::EN_MASK;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Fixed total sector count, locked after first write
  // ----------------------------------------------------------------
  assign tot_wr_ok = wr_pend_r && (wr_addr_r == idpw_pkg::OFF_TOTAL);

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      total_r      <= idpw_pkg::TOTAL_RST;
      total_lock_r <= 1'b0;
    end else begin
      // A media change reopens the value on removable devices
      if (REMOVABLE && media_changed) begin
        total_lock_r <= 1'b0;
      end
      if (tot_wr_ok && (!total_lock_r ||
                        (REMOVABLE && media_changed))) begin
        total_r      <= hwdata;
        total_lock_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hreadyout  = hready_r;
  assign hresp      = hresp_r;
  assign hrdata     = hrdata_r;
  assign word_data  = word_data_r;
  assign word_valid = word_valid_r;
  assign word_hit   = word_hit_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  property p_heads;
    word_rd && word_idx == idpw_pkg::W_HEADS
      |=> word_valid && word_data == $past(geom_r[15:0]);
  endproperty
  a_heads: assert property (p_heads)
    else $error("word 55 not current heads");

  property p_cap_pair;
    word_rd && word_idx == idpw_pkg::W_CAPLO ##1
      word_rd && word_idx == idpw_pkg::W_CAPHI
      |=> word_data == $past(cap_r[31:16], 2);
  endproperty
  a_cap_pair: assert property (p_cap_pair)
    else $error("capacity high half not from paired snapshot");

  property p_multi;
    word_rd && word_idx == idpw_pkg::W_MULTI
      |=> word_data[15:9] == 7'h00 &&
          word_data[8] == $past(multi_ok_r) &&
          word_data[7:0] == $past(multi_cnt_r);
  endproperty
  a_multi: assert property (p_multi)
    else $error("word 59 wrong");

  property p_total_lo;
    word_rd && word_idx == idpw_pkg::W_TOTLO
      |=> word_data == $past(total_r[15:0]);
  endproperty
  a_total_lo: assert property (p_total_lo)
    else $error("word 60 not total low half");

  property p_dma;
    word_rd && word_idx == idpw_pkg::W_DMA
      |=> $countones(word_data[10:8]) <= 1 &&
          word_data[15:11] == 5'h00 && word_data[7:3] == 5'h00 &&
          word_data[2:0] == DMA_SUP;
  endproperty
  a_dma: assert property (p_dma)
    else $error("word 63 mode bits wrong");

  property p_pio;
    word_rd && word_idx == idpw_pkg::W_PIO
      |=> word_data == {8'h00, PIO_SUP};
  endproperty
  a_pio: assert property (p_pio)
    else $error("word 64 wrong");

  property p_rsvd;
    word_rd && word_idx >= 8'h45 && word_idx <= 8'h4F &&
      word_idx != idpw_pkg::W_QDEPTH
      |=> word_data == 16'h0000 && word_hit;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved word not zero");

  property p_qdepth;
    word_rd && word_idx == idpw_pkg::W_QDEPTH
      |=> word_data[15:5] == 11'h000;
  endproperty
  a_qdepth: assert property (p_qdepth)
    else $error("word 75 reserved bits set");

  property p_sig;
    word_rd && (word_idx == idpw_pkg::W_SUP2 ||
                word_idx == idpw_pkg::W_SUPX)
      |=> word_data[15:14] == 2'h1;
  endproperty
  a_sig: assert property (p_sig)
    else $error("signature bits of word 83 or 84 wrong");

  property p_ext;
    word_rd && word_idx == idpw_pkg::W_SUPX
      |=> word_data == 16'h4000;
  endproperty
  a_ext: assert property (p_ext)
    else $error("word 84 wrong");

  property p_ena;
    word_rd && word_idx == idpw_pkg::W_ENA
      |=> (word_data & idpw_pkg::EN_MASK) ==
          ($past(en_r) & SUP82 & idpw_pkg::EN_MASK);
  endproperty
  a_ena: assert property (p_ena)
    else $error("word 85 does not track enables");

  property p_outside;
    word_rd && (word_idx < idpw_pkg::W_FIRST ||
                word_idx > idpw_pkg::W_LAST)
      |=> !word_hit && word_data == 16'h0000;
  endproperty
  a_outside: assert property (p_outside)
    else $error("index outside range answered");

  property p_lock;
    total_lock_r && !media_changed |=> total_r == $past(total_r);
  endproperty
  a_lock: assert property (p_lock)
    else $error("fixed total changed while locked");

endmodule

// ==== common/idpw_pkg.sv ====
// Constants shared by the identify parameter word block
package idpw_pkg;

  // ----------------------------------------------------------------
  // Register offsets on the AHB-Lite slave
  // ----------------------------------------------------------------
  localparam logic [7:0]  OFF_GEOM      = 8'h00;
  localparam logic [7:0]  OFF_CAP       = 8'h04;
  localparam logic [7:0]  OFF_MULTI     = 8'h08;
  localparam logic [7:0]  OFF_DMASEL    = 8'h0C;
  localparam logic [7:0]  OFF_ENABLE    = 8'h10;
  localparam logic [7:0]  OFF_TOTAL     = 8'h14;
  localparam logic [7:0]  OFF_STATUS    = 8'h18;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int          MULTI_OK_BIT  = 8;
  localparam int          STAT_LOCK_BIT = 8;
  localparam int          STAT_CAPP_BIT = 9;
  localparam int          STAT_TOTP_BIT = 10;
  localparam logic [31:0] GEOM_RST      = 32'h0000_0000;
  localparam logic [31:0] CAP_RST       = 32'h0000_0000;
  localparam logic [31:0] TOTAL_RST     = 32'h0000_0000;
  localparam logic [7:0]  MULTI_RST     = 8'h00;
  localparam logic [15:0] EN_RST        = 16'h0000;

  // ----------------------------------------------------------------
  // Identification word indices
  // ----------------------------------------------------------------
  localparam logic [7:0]  W_HEADS  = 8'h37;
  localparam logic [7:0]  W_SPT    = 8'h38;
  localparam logic [7:0]  W_CAPLO  = 8'h39;
  localparam logic [7:0]  W_CAPHI  = 8'h3A;
  localparam logic [7:0]  W_MULTI  = 8'h3B;
  localparam logic [7:0]  W_TOTLO  = 8'h3C;
  localparam logic [7:0]  W_TOTHI  = 8'h3D;
  localparam logic [7:0]  W_DMA    = 8'h3F;
  localparam logic [7:0]  W_PIO    = 8'h40;
  localparam logic [7:0]  W_DMAMIN = 8'h41;
  localparam logic [7:0]  W_DMAREC = 8'h42;
  localparam logic [7:0]  W_PIOMIN = 8'h43;
  localparam logic [7:0]  W_PIORDY = 8'h44;
  localparam logic [7:0]  W_QDEPTH = 8'h4B;
  localparam logic [7:0]  W_MAJOR  = 8'h50;
  localparam logic [7:0]  W_MINOR  = 8'h51;
  localparam logic [7:0]  W_SUP    = 8'h52;
  localparam logic [7:0]  W_SUP2   = 8'h53;
  localparam logic [7:0]  W_SUPX   = 8'h54;
  localparam logic [7:0]  W_ENA    = 8'h55;
  localparam logic [7:0]  W_FIRST  = 8'h37;
  localparam logic [7:0]  W_LAST   = 8'h55;

  // Bits 15:14 of the signature words read 0 then 1
  localparam logic [1:0]  SIG_TOP  = 2'h1;
  // Feature bits that track enable state in the enabled word
  localparam logic [15:0] EN_MASK  = 16'h01E3;
  // Supported bits echoed in the enabled word
  localparam logic [15:0] ECHO_MSK = 16'h761C;

  // ----------------------------------------------------------------
  // Bus constants and mode encoding
  // ----------------------------------------------------------------
  localparam logic [2:0]  HSIZE_WORD = 3'h2;

  typedef enum logic [1:0] {
    DMA_NONE = 2'b00,
    DMA_M0   = 2'b01,
    DMA_M1   = 2'b10,
    DMA_M2   = 2'b11
  } idpw_dma_t;

endpackage

// ==== common/idpw_cfg_if.sv ====
// Live parameters and word lookup between register file and image
`timescale 1ns/100ps
interface idpw_cfg_if;
  logic [15:0]       heads;
  logic [15:0]       spt;
  logic [31:0]       cap;
  logic [31:0]       total;
  logic              multi_ok;
  logic [7:0]        multi_cnt;
  idpw_pkg::idpw_dma_t dma_sel;
  logic [15:0]       en;
  logic [7:0]        idx;
  logic [15:0]       word;
  logic              hit;

  modport src (output heads, spt, cap, total, multi_ok, multi_cnt,
               output dma_sel, en, idx, input word, hit);
  modport img (input heads, spt, cap, total, multi_ok, multi_cnt,
               input dma_sel, en, idx, output word, hit);
endinterface

// ==== hw/idpw_word_mux.sv ====
// Builds one identification word, indices 55 to 85
`timescale 1ns/100ps
module idpw_word_mux #(
  parameter logic [2:0]  DMA_SUP   = 3'h7,
  parameter logic [7:0]  PIO_SUP   = 8'h03,
  parameter logic [15:0] DMA_MIN   = 16'h0078,
  parameter logic [15:0] DMA_REC   = 16'h0078,
  parameter logic [15:0] PIO_MIN   = 16'h0078,
  parameter logic [15:0] PIO_RDY   = 16'h0078,
  parameter logic [4:0]  QDEPTH    = 5'h00,
  parameter logic [15:0] MAJOR_VER = 16'h001E,
  parameter logic [15:0] MINOR_VER = 16'h0000,
  parameter logic [15:0] SUP82     = 16'h7E6B,
  parameter logic [4:0]  SUP83     = 5'h00
) (
  idpw_cfg_if.img c
);

  logic [2:0] sel3;

  // One-hot selected mode bits, never more than one
  always_comb begin
    case (c.dma_sel)
      idpw_pkg::DMA_M0: sel3 = 3'h1;
      idpw_pkg::DMA_M1: sel3 = 3'h2;
      idpw_pkg::DMA_M2: sel3 = 3'h4;
      default:          sel3 = 3'h0;
    endcase
  end

  always_comb begin
    c.word = 16'h0000;
    c.hit  = 1'b1;
    case (c.idx)
      idpw_pkg::W_HEADS:  c.word = c.heads;
      idpw_pkg::W_SPT:    c.word = c.spt;
      idpw_pkg::W_CAPLO:  c.word = c.cap[15:0];
      idpw_pkg::W_CAPHI:  c.word = c.cap[31:16];
      idpw_pkg::W_MULTI:  c.word = {7'h00, c.multi_ok, c.multi_cnt};
      idpw_pkg::W_TOTLO:  c.word = c.total[15:0];
      idpw_pkg::W_TOTHI:  c.word = c.total[31:16];
      idpw_pkg::W_DMA:    c.word = {5'h00, sel3, 5'h00, DMA_SUP};
      idpw_pkg::W_PIO:    c.word = {8'h00, PIO_SUP};
      idpw_pkg::W_DMAMIN: c.word = DMA_MIN;
      idpw_pkg::W_DMAREC: c.word = DMA_REC;
      idpw_pkg::W_PIOMIN: c.word = PIO_MIN;
      idpw_pkg::W_PIORDY: c.word = PIO_RDY;
      idpw_pkg::W_QDEPTH: c.word = {11'h000, QDEPTH};
      idpw_pkg::W_MAJOR:  c.word = MAJOR_VER;
      idpw_pkg::W_MINOR:  c.word = MINOR_VER;
      idpw_pkg::W_SUP:    c.word = SUP82;
      idpw_pkg::W_SUP2:   c.word = {idpw_pkg::SIG_TOP, 9'h000, SUP83};
      idpw_pkg::W_SUPX:   c.word = {idpw_pkg::SIG_TOP, 14'h0000};
      // Enabled bits only count where the feature is supported
      idpw_pkg::W_ENA:    c.word = SUP82 & (idpw_pkg::ECHO_MSK |
                                   (c.en & idpw_pkg::EN_MASK));
      default: begin
        // Reserved words inside the range read zero
        c.word = 16'h0000;
        c.hit  = (c.idx >= idpw_pkg::W_FIRST) &&
                 (c.idx <= idpw_pkg::W_LAST);
      end
    endcase
  end

endmodule

// ==== sim/idpw_host_model.sv ====
// Host adapter model pulling identification words in index order
`timescale 1ns/100ps
module idpw_host_model (
  input  wire logic        core_clk,
  output logic             word_rd,
  output logic [7:0]       word_idx,
  input  wire logic [15:0] word_data,
  input  wire logic        word_valid,
  input  wire logic        word_hit
);
  logic [16:0] got [0:255];
  int          n_got;

  initial begin
    word_rd = 1'b0;
    word_idx = 8'h00;
    n_got = 0;
  end

  // --------------------------------------------------------------
  // Capture of each returned word with its ownership flag
  // --------------------------------------------------------------
  always @(posedge core_clk) begin
    if (word_valid === 1'b1) begin
      got[n_got] <= {word_hit, word_data};
      n_got <= n_got + 1;
    end
  end

  // Reads n words from first on; slow leaves gaps with a junk index
  task automatic run(input logic [7:0] first, input int n, input bit slow);
    for (int k = 0; k < n; k++) begin
      word_rd <= 1'b1;
      word_idx <= first + k[7:0];
      @(posedge core_clk);
      if (slow) begin
        word_rd <= 1'b0;
        word_idx <= ~word_idx;
        repeat (2) @(posedge core_clk);
      end
    end
    word_rd <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask
endmodule

// ==== sim/testbench.sv ====
// Self-checking bench for the identify parameter word block
`timescale 1ns/100ps
module testbench;
  logic        core_clk, reset_n, hsel, hwrite, hreadyout, hresp;
  logic        media_changed, word_rd, word_valid, word_hit;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  word_idx;
  logic [15:0] word_data;
  logic [31:0] haddr, hwdata, hrdata, rd, tot_w;
  logic [31:0] geom, cap, total, multi, dma, en;
  int          error_cnt, compares, base;

  idpw_top #(.DMA_REC(16'h0096), .PIO_MIN(16'h00F0),
    .QDEPTH(5'h1F), .MINOR_VER(16'h0017),
    .SUP83(5'h15)) u_dut (
    .core_clk(core_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .media_changed(media_changed), .word_rd(word_rd),
    .word_idx(word_idx), .word_data(word_data), .word_valid(word_valid),
    .word_hit(word_hit));

  idpw_host_model u_host (
    .core_clk(core_clk), .word_rd(word_rd), .word_idx(word_idx),
    .word_data(word_data), .word_valid(word_valid), .word_hit(word_hit));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic ahb(input logic w, input logic [31:0] a, d,
                     input logic [2:0] sz, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= sz;
    // Only the watchdog ends a stalled wait
    do begin
      @(posedge core_clk);
    end while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge core_clk);
    end while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  function automatic logic [16:0] exp_word(input int i);
    logic [15:0] w;
    case (i)
      55: w = geom[15:0];
      56: w = geom[31:16];
      57: w = cap[15:0];
      58: w = cap[31:16];
      59: w = multi[15:0];
      60: w = total[15:0];
      61: w = total[31:16];
      63: w = (dma == 0) ? 16'h0007 : 16'h0007 | (16'h0080 << dma);
      64: w = 16'h0003;
      65: w = 16'h0078;
      66: w = 16'h0096;
      67: w = 16'h00F0;
      68: w = 16'h0078;
      75: w = 16'h001F;
      80: w = 16'h001E;
      81: w = 16'h0017;
      82: w = 16'h7E6B;
      83: w = 16'h4015;
      84: w = 16'h4000;
      85: w = 16'h7E6B & (16'h761C | en[15:0]);
      default: w = 16'h0000;
    endcase
    return {i >= 55 && i <= 85, w};
  endfunction

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #200000;
    error_cnt++;
    summarize();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {hsel, hwrite, media_changed, reset_n} = 4'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    error_cnt = 0;
    compares = 0;
    rd = $urandom(32'hD120D331);
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    chk("hresp", hresp, 32'h0);
    for (int r = 0; r < 4; r++) begin
      geom = $urandom;
      cap = $urandom;
      multi = $urandom;
      dma = $urandom;
      en = $urandom;
      tot_w = $urandom;
      ahb(1'b1, idpw_pkg::OFF_GEOM, geom, 3'h2, rd);
      ahb(1'b1, idpw_pkg::OFF_CAP, cap, 3'h2, rd);
      ahb(1'b1, idpw_pkg::OFF_MULTI, multi, 3'h2, rd);
      ahb(1'b1, idpw_pkg::OFF_DMASEL, {dma[31:2], r[1:0]}, 3'h2, rd);
      ahb(1'b1, idpw_pkg::OFF_ENABLE, en, 3'h2, rd);
      if (r == 2) begin
        media_changed <= 1'b1;
        @(posedge core_clk);
        media_changed <= 1'b0;
      end
      ahb(1'b1, idpw_pkg::OFF_TOTAL, tot_w, 3'h2, rd);
      if (r == 0) total = tot_w;
      multi = multi & 32'h0000_01FF;
      dma = r;
      en = en & 32'h0000_01E3;
      ahb(1'b0, idpw_pkg::OFF_STATUS, 32'h0, 3'h2, rd);
      chk("total lock", rd[8], 32'h1);
      base = u_host.n_got;
      u_host.run(8'd54, 33, r[0]);
      for (int k = 0; k < 33; k++) begin
        chk("word", u_host.got[base + k], exp_word(54 + k));
        chk("word", u_host.got[base + k], exp_word(54 + k));
        chk("word", u_host.got[base + k], exp_word(54 + k));
        chk("word", u_host.got[base + k], exp_word(54 + k));
        chk("word", u_host.got[base + k], exp_word(54 + k));
        chk("word", u_host.got[base + k], exp_word(54 + k));
        chk("word", u_host.got[base + k], exp_word(54 + k));
        chk("word", u_host.got[base + k], exp_word(54 + k));
      end
    end
    ahb(1'b1, idpw_pkg::OFF_GEOM, ~geom, 3'h0, rd);
    ahb(1'b0, idpw_pkg::OFF_GEOM, 32'h0, 3'h2, rd);
    chk("geom after byte write", rd, geom);
    ahb(1'b0, 32'h0000_0040, 32'h0, 3'h2, rd);
    chk("unmapped read", rd, 32'h0);
    base = u_host.n_got;
    u_host.run(8'd57, 1, 1'b0);
    ahb(1'b1, idpw_pkg::OFF_CAP, ~cap, 3'h2, rd);
    u_host.run(8'd58, 1, 1'b0);
    u_host.run(8'd58, 1, 1'b0);
    chk("cap low", u_host.got[base], {1'b1, cap[15:0]});
    chk("cap high pair", u_host.got[base + 1], {1'b1, cap[31:16]});
    chk("cap high live", u_host.got[base + 2], {1'b1, ~cap[31:16]});
    summarize();
  end
endmodule
